// ==== rtl/intr_lowpower_pkg.sv ====
package intr_lowpower_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] PENDING_LOW_OFS = 8'h00;
	localparam logic [7:0] PENDING_MID_OFS = 8'h04;
	localparam logic [7:0] PENDING_HIGH_OFS = 8'h08;
	localparam logic [7:0] BREAK_STATUS_OFS = 8'h0c;
	localparam logic [7:0] BREAK_FLAG_CTRL_OFS = 8'h10;
	localparam logic [7:0] CONFIG_ONE_OFS = 8'h14;
	localparam logic [7:0] LOWPOWER_STATE_OFS = 8'h18;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int BREAK_STOP_WAIT_BIT = 0;
	localparam int BREAK_CLEAR_ENABLE_BIT = 0;
	localparam int SHORT_RECOVERY_BIT = 0;
	localparam int WATCHDOG_DISABLE_BIT = 1;
	localparam logic BREAK_CLEAR_ENABLE_RST = 1'b0;
	localparam logic SHORT_RECOVERY_RST = 1'b0;
	localparam logic WATCHDOG_DISABLE_RST = 1'b0;

	// ****************************************
	// Interrupt sources and vectors
	// ****************************************
	localparam int NUM_SOURCES = 17;
	localparam logic [15:0] VEC_FIRST_SOURCE = 16'hfffa;
	localparam logic [15:0] VEC_SOFTWARE_INTERRUPT = 16'hfffc;
	localparam logic [15:0] VEC_RESET = 16'hfffe;

	// ****************************************
	// Counter and recovery counts
	// ****************************************
	localparam int COUNTER_WIDTH = 12;
	localparam logic [11:0] RECOVERY_LONG_LAST = 12'hfff;
	localparam logic [11:0] RECOVERY_SHORT_LAST = 12'h01f;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER} power_state_t;

endpackage

// ==== rtl/intr_lowpower_ctrl.sv ====
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module intr_lowpower_ctrl
	import intr_lowpower_pkg::*;
(
	// Clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_clk_en,
	// AXI4-Lite slave
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// Interrupt, break and reset sources
	input wire logic [16:0] i_irq_req,
	input wire logic i_break_irq,
	input wire logic i_break_exit,
	input wire logic i_ext_rst_pin,
	input wire logic [3:0] i_reset_src,
	// CPU core, peripheral clock, watchdog and flag-clear controls
	input wire logic i_cpu_ibit,
	input wire logic i_insn_done,
	input wire logic i_vector_ack,
	input wire logic i_wait_exec,
	input wire logic i_stop_exec,
	output logic [15:0] o_vector_addr,
	output logic o_irq_take,
	output logic o_clear_ibit,
	output logic o_cpu_reset,
	output logic o_cpu_clk_en,
	output logic o_periph_clk_en,
	output logic o_watchdog_run,
	output logic o_flag_clear_allow,
	output logic o_lowpower_exit
);

	// ****************************************
	// State
	// ****************************************
	power_state_t state;
	logic [11:0] counter;
	logic rst_pin_meta, rst_pin_sync;
	logic latched, break_state, break_stop_wait_status;
	logic break_clear_enable, short_recovery_select, watchdog_disable_option;
	logic reset_any, irq_ok, exit_now, rec_done, arb_go;
	logic [15:0] next_vector;
	logic wr_go, rd_go, wr_hit;
	logic [31:0] rd_val;
	logic rd_hit;

	// Pin passes two flops before use
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			rst_pin_meta <= 1'b0;
			rst_pin_sync <= 1'b0;
		end
		else if (i_clk_en)
		begin
			rst_pin_meta <= i_ext_rst_pin;
			rst_pin_sync <= rst_pin_meta;
		end
	end

	// ****************************************
	// Arbitration
	// ****************************************
	assign reset_any = rst_pin_sync | (|i_reset_src);
	assign irq_ok = (|i_irq_req) & !i_cpu_ibit;
	assign exit_now = rst_pin_sync | irq_ok | i_break_irq;
	assign rec_done = (state == ST_RECOVER) &&
		(counter == (short_recovery_select ? RECOVERY_SHORT_LAST : RECOVERY_LONG_LAST));
	// A latched request blocks new arbitration until acknowledged
	assign arb_go = !reset_any && !latched && (i_break_irq || irq_ok) &&
		((state == ST_RUN && i_insn_done) || (state == ST_WAIT) || rec_done);

	always_comb
	begin
		next_vector = VEC_SOFTWARE_INTERRUPT;
		if (!i_break_irq)
		begin
			for (int i = NUM_SOURCES - 1; i >= 0; i--)
			begin
				if (i_irq_req[i])
					next_vector = VEC_FIRST_SOURCE - 16'(2 * i);
			end
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			o_vector_addr <= VEC_RESET;
			o_irq_take <= 1'b0;
			latched <= 1'b0;
			o_cpu_reset <= 1'b0;
		end
		else if (i_clk_en)
		begin
			o_cpu_reset <= reset_any;
			o_irq_take <= arb_go;
			if (reset_any)
			begin
				o_vector_addr <= VEC_RESET;
				latched <= 1'b0;
			end
			else if (arb_go)
			begin
				o_vector_addr <= next_vector;
				latched <= 1'b1;
			end
			else if (i_vector_ack)
				latched <= 1'b0;
		end
	end

	// ****************************************
	// Break state and flag protection
	// ****************************************
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			break_state <= 1'b0;
		else if (i_clk_en)
		begin
			if (reset_any || i_break_exit)
				break_state <= 1'b0;
			else if (arb_go && i_break_irq)
				break_state <= 1'b1;
		end
	end

	// Peripherals gate every clear step with this, so a half-done
	// two-step clear cannot finish inside break while break_clear_enable is 0
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			o_flag_clear_allow <= 1'b1;
		else if (i_clk_en)
			o_flag_clear_allow <= !break_state || break_clear_enable;
	end

	// ****************************************
	// Low-power state machine
	// ****************************************
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			state <= ST_RUN;
		else if (i_clk_en)
		begin
			if (reset_any)
				state <= ST_RUN;
			else
			begin
				case (state)
					ST_RUN:
						if (i_stop_exec)
							state <= ST_STOP;
						else if (i_wait_exec)
							state <= ST_WAIT;
					ST_WAIT:
						if (exit_now)
							state <= ST_RUN;
					ST_STOP:
						if (exit_now)
							state <= ST_RECOVER;
					ST_RECOVER:
						if (rec_done)
							state <= ST_RUN;
					default:
						state <= ST_RUN;
				endcase
			end
		end
	end

	// Counter runs free except while stopped
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			counter <= '0;
		else if (i_clk_en)
		begin
			if (state == ST_STOP || (state == ST_RUN && i_stop_exec))
				counter <= '0;
			else
				counter <= counter + 12'h001;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			o_clear_ibit <= 1'b0;
			o_cpu_clk_en <= 1'b1;
			o_periph_clk_en <= 1'b1;
			o_watchdog_run <= 1'b1;
			o_lowpower_exit <= 1'b0;
		end
		else if (i_clk_en)
		begin
			o_clear_ibit <= state == ST_RUN && (i_wait_exec || i_stop_exec);
			o_cpu_clk_en <= state == ST_RUN;
			o_periph_clk_en <= state != ST_STOP && state != ST_RECOVER;
			o_watchdog_run <= !watchdog_disable_option && state != ST_STOP;
			o_lowpower_exit <= (state == ST_WAIT || state == ST_STOP) && exit_now;
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	assign wr_go = i_awvalid && i_wvalid && !o_awready && !o_bvalid;
	assign rd_go = i_arvalid && !o_arready && !o_rvalid;
	assign wr_hit = i_awaddr == BREAK_STATUS_OFS || i_awaddr == BREAK_FLAG_CTRL_OFS ||
		i_awaddr == CONFIG_ONE_OFS || i_awaddr == PENDING_LOW_OFS ||
		i_awaddr == PENDING_MID_OFS || i_awaddr == PENDING_HIGH_OFS ||
		i_awaddr == LOWPOWER_STATE_OFS;

	always_comb
	begin
		rd_val = 32'h00000000;
		rd_hit = 1'b1;
		case (i_araddr)
			PENDING_LOW_OFS: rd_val[7:0] = {i_irq_req[5:0], 2'b00};
			PENDING_MID_OFS: rd_val[7:0] = i_irq_req[13:6];
			PENDING_HIGH_OFS: rd_val[7:0] = {5'h00, i_irq_req[16:14]};
			BREAK_STATUS_OFS: rd_val[BREAK_STOP_WAIT_BIT] = break_stop_wait_status;
			BREAK_FLAG_CTRL_OFS: rd_val[BREAK_CLEAR_ENABLE_BIT] = break_clear_enable;
			CONFIG_ONE_OFS:
			begin
				rd_val[SHORT_RECOVERY_BIT] = short_recovery_select;
				rd_val[WATCHDOG_DISABLE_BIT] = watchdog_disable_option;
			end
			LOWPOWER_STATE_OFS: rd_val[1:0] = state;
			default: rd_hit = 1'b0;
		endcase
	end

	// Pending registers take no write at all
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			break_clear_enable <= BREAK_CLEAR_ENABLE_RST;
			short_recovery_select <= SHORT_RECOVERY_RST;
			watchdog_disable_option <= WATCHDOG_DISABLE_RST;
		end
		else if (i_clk_en && wr_go && i_wstrb[0])
		begin
			if (i_awaddr == BREAK_FLAG_CTRL_OFS)
				break_clear_enable <= i_wdata[BREAK_CLEAR_ENABLE_BIT];
			if (i_awaddr == CONFIG_ONE_OFS)
			begin
				short_recovery_select <= i_wdata[SHORT_RECOVERY_BIT];
				watchdog_disable_option <= i_wdata[WATCHDOG_DISABLE_BIT];
			end
		end
	end

	// Set wins over a simultaneous zero write
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
			break_stop_wait_status <= 1'b0;
		else if (i_clk_en)
		begin
			if (reset_any)
				break_stop_wait_status <= 1'b0;
			else if ((state == ST_WAIT || state == ST_STOP) && i_break_irq)
				break_stop_wait_status <= 1'b1;
			else if (wr_go && i_wstrb[0] && i_awaddr == BREAK_STATUS_OFS &&
				!i_wdata[BREAK_STOP_WAIT_BIT])
				break_stop_wait_status <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
		end
		else if (i_clk_en)
		begin
			o_awready <= wr_go;
			o_wready <= wr_go;
			if (wr_go)
			begin
				o_bvalid <= 1'b1;
				o_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (i_bready)
				o_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_b)
		begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h00000000;
			o_rresp <= RESP_OKAY;
		end
		else if (i_clk_en)
		begin
			o_arready <= rd_go;
			if (rd_go)
			begin
				o_rvalid <= 1'b1;
				o_rdata <= rd_val;
				o_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (i_rready)
				o_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	AST_STOP_HALTS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_clk_en && state == ST_STOP |=> !o_periph_clk_en && !o_cpu_clk_en)
		else $error("clocks not halted in stop");
	AST_STOP_COUNTER: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_clk_en && state == ST_STOP |=> counter == 12'h000)
		else $error("counter not held in stop");
	AST_WAIT_CLOCKS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_clk_en && state == ST_WAIT |=> !o_cpu_clk_en && o_periph_clk_en)
		else $error("wait clock gating wrong");
	AST_WAIT_WAKE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_clk_en && state == ST_WAIT && irq_ok && !latched && !reset_any |=> o_irq_take)
		else $error("wait wake not one cycle later");
	AST_SHORT_REC: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		rec_done && short_recovery_select |-> counter == 12'h01f)
		else $error("short recovery count wrong");
	AST_BREAK_VEC: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_clk_en && arb_go && i_break_irq |=> o_vector_addr == 16'hfffc && break_state)
		else $error("break vector wrong");
	AST_PROTECT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_clk_en && break_state && !break_clear_enable |=> !o_flag_clear_allow)
		else $error("flags not protected in break");
	AST_CLEAR_IBIT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_clk_en && state == ST_RUN && i_wait_exec |=> o_clear_ibit)
		else $error("mask not cleared on wait");
	AST_STATUS_SET: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_clk_en && state == ST_STOP && i_break_irq && !reset_any |=> break_stop_wait_status)
		else $error("stop/wait status not set");
	AST_LATCH_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		latched && !i_vector_ack && !reset_any && i_clk_en |=> $stable(o_vector_addr))
		else $error("latched vector changed");
	AST_PRIO: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_clk_en && arb_go && !i_break_irq && i_irq_req[0] |=> o_vector_addr == 16'hfffa)
		else $error("highest source not chosen");

endmodule // intr_lowpower_ctrl

`default_nettype wire

// ==== testbench/cpu_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module cpu_core_model
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// From the controller
	input wire logic irq_take,
	input wire logic clear_ibit,
	input wire logic cpu_clk_en,
	// From the bench
	input wire logic cli,
	// To the controller
	output logic insn_done,
	output logic vector_ack,
	output logic ibit
);
	logic [1:0] icnt;
	logic [2:0] acnt;

	// Instructions end only while the core is clocked
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			icnt <= 2'h0;
		else if (cpu_clk_en)
			icnt <= icnt + 2'h1;
	end
	assign insn_done = cpu_clk_en && icnt == 2'h3;

	// Slow vector fetch keeps the latch busy for a while
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			acnt <= 3'h0;
		else if (irq_take)
			acnt <= 3'h4;
		else if (acnt != 3'h0)
			acnt <= acnt - 3'h1;
	end
	assign vector_ack = acnt == 3'h1;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			ibit <= 1'h1;
		else if (irq_take)
			ibit <= 1'h1;
		else if (clear_ibit || cli)
			ibit <= 1'h0;
	end
endmodule // cpu_core_model

`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("mismatch %s exp %h got %h", nm, e, a); end end

module testbench import intr_lowpower_pkg::*;;
	typedef struct packed {logic [7:0] a; logic [16:0] q; logic [31:0] d; logic [1:0] r;} row_t;
	row_t rows [9] = '{'{PENDING_LOW_OFS, 17'h00001, 32'h04, RESP_OKAY},
		'{PENDING_LOW_OFS, 17'h1ffff, 32'hfc, RESP_OKAY},
		'{PENDING_MID_OFS, 17'h03fc0, 32'hff, RESP_OKAY},
		'{PENDING_MID_OFS, 17'h00040, 32'h01, RESP_OKAY},
		'{PENDING_HIGH_OFS, 17'h1c000, 32'h07, RESP_OKAY},
		'{PENDING_HIGH_OFS, 17'h00000, 32'h00, RESP_OKAY},
		'{BREAK_FLAG_CTRL_OFS, 17'h0, 32'h0, RESP_OKAY},
		'{CONFIG_ONE_OFS, 17'h0, 32'h0, RESP_OKAY},
		'{8'h40, 17'h0, 32'h0, RESP_SLVERR}};
	logic i_sys_clk = 1'h0;
	logic i_rst_b = 1'h0;
	logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0;
	logic [31:0] i_wdata = 32'h0;
	logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
	logic [16:0] i_irq_req = 17'h0;
	logic i_break_irq = 1'h0, i_break_exit = 1'h0, i_wait_exec = 1'h0, i_stop_exec = 1'h0;
	logic cli = 1'h0;
	logic i_clk_en = 1'h1, i_ext_rst_pin = 1'h0;
	logic [3:0] i_reset_src = 4'h0;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq_take, o_clear_ibit;
	logic o_cpu_reset, o_cpu_clk_en, o_periph_clk_en, o_watchdog_run, o_flag_clear_allow;
	logic o_lowpower_exit, i_cpu_ibit, i_insn_done, i_vector_ack;
	logic [1:0] o_bresp, o_rresp, rs;
	logic [31:0] o_rdata, rdv;
	logic [15:0] o_vector_addr;
	int n_mismatch = 0, checks = 0, cyc = 0, n = 0;

	always #5 i_sys_clk = ~i_sys_clk;

	intr_lowpower_ctrl dut (.i_sys_clk, .i_rst_b, .i_clk_en, .i_awaddr, .i_awvalid,
		.o_awready, .i_wdata, .i_wstrb(4'hf), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
		.i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_irq_req,
		.i_break_irq, .i_break_exit, .i_ext_rst_pin, .i_reset_src, .i_cpu_ibit, .i_insn_done,
		.i_vector_ack, .i_wait_exec, .i_stop_exec, .o_vector_addr, .o_irq_take, .o_clear_ibit,
		.o_cpu_reset, .o_cpu_clk_en, .o_periph_clk_en, .o_watchdog_run, .o_flag_clear_allow,
		.o_lowpower_exit);
	cpu_core_model cpu (.clk(i_sys_clk), .rst_b(i_rst_b), .irq_take(o_irq_take),
		.clear_ibit(o_clear_ibit), .cpu_clk_en(o_cpu_clk_en), .cli, .insn_done(i_insn_done),
		.vector_ack(i_vector_ack), .ibit(i_cpu_ibit));

	// ****************************************
	// Bus and sequencing tasks
	// ****************************************
	task automatic tick(input int k);
		repeat (k) @(posedge i_sys_clk);
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'h1;
		i_wvalid <= 1'h1;
		i_bready <= 1'h1;
		do
		begin
			@(posedge i_sys_clk);
			if (o_awready)
			begin
				i_awvalid <= 1'h0;
				i_wvalid <= 1'h0;
			end
		end
		while (!o_bvalid);
		rs = o_bresp;
		i_bready <= 1'h0;
	endtask

	task automatic axr(input logic [7:0] a);
		@(posedge i_sys_clk);
		i_araddr <= a;
		i_arvalid <= 1'h1;
		i_rready <= 1'h1;
		do
		begin
			@(posedge i_sys_clk);
			if (o_arready)
				i_arvalid <= 1'h0;
		end
		while (!o_rvalid);
		rdv = o_rdata;
		rs = o_rresp;
		i_rready <= 1'h0;
	endtask

	// Counts edges until the take pulse is sampled
	task automatic wt();
		n = 0;
		do
		begin
			@(posedge i_sys_clk);
			n++;
		end
		while (!o_irq_take && n < 5000);
		// A take that never comes is a failure, not a silent pass
		if (!o_irq_take)
			n_mismatch++;
	endtask

	task automatic enter(input logic stop);
		@(posedge i_sys_clk);
		i_wait_exec <= !stop;
		i_stop_exec <= stop;
		@(posedge i_sys_clk);
		i_wait_exec <= 1'h0;
		i_stop_exec <= 1'h0;
	endtask

	task automatic brk_end();
		i_break_exit <= 1'h1;
		@(posedge i_sys_clk);
		i_break_exit <= 1'h0;
		tick(6);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Ceiling covers one long recovery plus the short scenarios
	always @(posedge i_sys_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_mismatch++;
			conclude();
		end
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		tick(2);
		i_rst_b <= 1'h1;
		@(posedge i_sys_clk);
		`CHK("vector", VEC_RESET, o_vector_addr)
		foreach (rows[k])
		begin
			i_irq_req <= rows[k].q;
			axr(rows[k].a);
			`CHK("rdata", rows[k].d, rdv)
			`CHK("rresp", rows[k].r, rs)
		end
		i_irq_req <= 17'h00001;
		axw(PENDING_LOW_OFS, 32'h0);
		`CHK("bresp", RESP_OKAY, rs)
		axw(8'h40, 32'h0);
		`CHK("bresp_bad", RESP_SLVERR, rs)
		axr(PENDING_LOW_OFS);
		`CHK("ro", 32'h04, rdv)
		for (int s = 0; s <= NUM_SOURCES; s++)
		begin
			cli <= 1'h1;
			i_irq_req <= (s == NUM_SOURCES) ? 17'h10014 : 17'h1 << s;
			@(posedge i_sys_clk);
			cli <= 1'h0;
			wt();
			`CHK("vec", VEC_FIRST_SOURCE - 16'(2 * (s % NUM_SOURCES ? s : 2 * s / 17)), o_vector_addr)
			i_irq_req <= 17'h0;
			tick(6);
		end
		i_break_irq <= 1'h1;
		wt();
		`CHK("brk_vec", VEC_SOFTWARE_INTERRUPT, o_vector_addr)
		i_break_irq <= 1'h0;
		tick(6);
		`CHK("allow", 1'h0, o_flag_clear_allow)
		axw(BREAK_FLAG_CTRL_OFS, 32'h1);
		tick(2);
		`CHK("allow", 1'h1, o_flag_clear_allow)
		brk_end();
		axw(BREAK_FLAG_CTRL_OFS, 32'h0);
		enter(1'h0);
		@(posedge i_sys_clk);
		`CHK("clr_i", 1'h1, o_clear_ibit)
		@(posedge i_sys_clk);
		`CHK("cpu_clk", 1'h0, o_cpu_clk_en)
		`CHK("per_clk", 1'h1, o_periph_clk_en)
		`CHK("wdog", 1'h1, o_watchdog_run)
		i_irq_req <= 17'h2;
		wt();
		`CHK("wake", 2, n)
		`CHK("lp_exit", 1'h1, o_lowpower_exit)
		`CHK("wvec", VEC_FIRST_SOURCE - 16'h2, o_vector_addr)
		i_irq_req <= 17'h0;
		tick(6);
		for (int m = 0; m < 2; m++)
		begin
			axw(CONFIG_ONE_OFS, 32'(1 - m));
			enter(1'h1);
			tick(3);
			`CHK("stop_clk", 1'h0, o_periph_clk_en || o_cpu_clk_en)
			i_irq_req <= 17'h4;
			wt();
			`CHK("recov", 1'h1, n > (m ? 4095 : 31) && n < (m ? 4101 : 37))
			`CHK("svec", VEC_FIRST_SOURCE - 16'h4, o_vector_addr)
			i_irq_req <= 17'h0;
			tick(6);
		end
		axw(CONFIG_ONE_OFS, 32'h1);
		for (int m = 0; m < 2; m++)
		begin
			enter(m[0]);
			tick(3);
			i_break_irq <= 1'h1;
			wt();
			i_break_irq <= 1'h0;
			axr(BREAK_STATUS_OFS);
			`CHK("sw_set", 1'h1, rdv[BREAK_STOP_WAIT_BIT])
			axw(BREAK_STATUS_OFS, 32'h0);
			axr(BREAK_STATUS_OFS);
			`CHK("sw_clr", 1'h0, rdv[BREAK_STOP_WAIT_BIT])
			brk_end();
		end
		for (int r = 0; r < 4; r++)
		begin
			i_reset_src <= 4'h1 << r;
			tick(3);
			`CHK("rst", 1'h1, o_cpu_reset)
			`CHK("rvec", VEC_RESET, o_vector_addr)
			i_reset_src <= 4'h0;
			tick(3);
		end
		// Pin reaches the reset output after two sync flops and one register
		i_ext_rst_pin <= 1'h1;
		tick(4);
		`CHK("pin_rst", 1'h1, o_cpu_reset)
		i_ext_rst_pin <= 1'h0;
		tick(4);
		`CHK("pin_rel", 1'h0, o_cpu_reset)
		// Enable low must freeze the reset output
		i_clk_en <= 1'h0;
		i_reset_src <= 4'h1;
		tick(3);
		`CHK("frozen", 1'h0, o_cpu_reset)
		i_clk_en <= 1'h1;
		tick(2);
		`CHK("thawed", 1'h1, o_cpu_reset)
		i_reset_src <= 4'h0;
		tick(3);
		axw(CONFIG_ONE_OFS, 32'h2);
		tick(2);
		`CHK("wdog_off", 1'h0, o_watchdog_run)
		conclude();
	end
endmodule // testbench

`default_nettype wire
